// [inc/eac_cfg.svh]
/*
  Constants of the EEPROM access controller: I/O offsets, control field
  positions, reset values and programming times.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef EAC_CFG_SVH
`define EAC_CFG_SVH

`define EAC_OFF_CTRL 6'h1F
`define EAC_OFF_DATA 6'h20
`define EAC_OFF_ADRL 6'h21
`define EAC_OFF_ADRH 6'h22

`define EAC_BIT_RE 0
`define EAC_BIT_PE 1
`define EAC_BIT_MPE 2
`define EAC_BIT_RIE 3
`define EAC_BIT_PM_LO 4
`define EAC_BIT_PM_HI 5

`define EAC_PM_RESET 2'b00
`define EAC_MPE_WINDOW 4
`define EAC_PE_STALL 2
`define EAC_RD_STALL 4

`define EAC_CLK_HZ 25000000
`define EAC_T_ATOMIC_US 3400
`define EAC_T_SPLIT_US 1800

`endif

// [inc/eac_pkg.sv]
/*
  Types of the EEPROM access controller.
  Assumes eac_cfg.svh is on the include path.
*/
package eac_pkg;

  typedef enum logic [1:0] {
    EAC_PM_ATOMIC = 2'b00,
    EAC_PM_ERASE = 2'b01,
    EAC_PM_WRITE = 2'b10,
    EAC_PM_RSVD = 2'b11
  } eac_mode_t;

  typedef enum logic [2:0] {
    EAC_ST_IDLE = 3'b001,
    EAC_ST_PROG = 3'b010,
    EAC_ST_DONE = 3'b100
  } eac_state_t;

  // One I/O access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } eac_io_t;

  // One command to the array
  typedef struct packed {
    logic erase;
    logic write;
    logic [8:0] addr;
    logic [7:0] data;
  } eac_nv_cmd_t;

endpackage

// [rtl/eac_ctrl.sv]
/*
  EEPROM access controller: control, address and data registers on the
  core I/O port, programming timer, read path, stall and ready request.
  Assumes a combinational-read array port and a core that honours stall.
*/
`timescale 1ns/1ns
`default_nettype none
`include "eac_cfg.svh"

module eac_ctrl
  import eac_pkg::*;
#(
  parameter int CLK_HZ = `EAC_CLK_HZ,
  parameter int T_ATOMIC_US = `EAC_T_ATOMIC_US,
  parameter int T_SPLIT_US = `EAC_T_SPLIT_US
)
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire eac_io_t io_req, // Core I/O access
  output logic [7:0] io_rdata, // Registered read data
  input wire logic global_irq_en, // Global flag of cpu_status_reg
  input wire logic [7:0] nv_rdata, // Array byte at the address register
  output eac_nv_cmd_t nv_cmd, // Array command, held while busy
  output logic nv_busy, // Array programming in progress
  output logic cpu_stall, // Holds the core
  output logic ready_irq // Level ready request
);

  localparam int CYC_ATOMIC =
    (CLK_HZ / 1000) * T_ATOMIC_US / 1000;
  localparam int CYC_SPLIT =
    (CLK_HZ / 1000) * T_SPLIT_US / 1000;
  localparam int TW = $clog2(CYC_ATOMIC + 1);

  initial
  begin
    if (CYC_ATOMIC < 1 || CYC_SPLIT < 1)
      $error("eac_ctrl: programming times shorter than one cycle");
  end

  eac_state_t state_reg;
  logic [1:0] mode_reg;
  logic rie_reg;
  logic mpe_reg;
  logic [2:0] mpe_cnt_reg;
  logic [8:0] adr_reg;
  logic [7:0] data_reg;
  logic [TW-1:0] timer_reg;
  logic [2:0] stall_cnt_reg;
  logic re_reg;

  logic wr_ctrl;
  logic pe_req;
  logic pe_start;
  logic rd_start;
  logic busy;
  logic [7:0] ctrl_view;
  eac_mode_t mode_now;

  assign busy = (state_reg != EAC_ST_IDLE);
  assign mode_now = eac_mode_t'(mode_reg);
  assign wr_ctrl = io_req.wr && io_req.addr == `EAC_OFF_CTRL;
  assign pe_req = wr_ctrl && io_req.wdata[`EAC_BIT_PE];
  // Reserved mode starts no programming
  assign pe_start = pe_req && mpe_reg && !busy
    && mode_now != EAC_PM_RSVD;
  assign rd_start = wr_ctrl && io_req.wdata[`EAC_BIT_RE]
    && !busy && !pe_req;

  // Mode bits: clocked reset; the async reset of the sequencer drops busy at once,
  // so they are cleared at the first clock edge inside reset
  always_ff @(posedge clk)
  begin
    if (!rst_n && !busy)
      mode_reg <= `EAC_PM_RESET;
    else if (wr_ctrl && !busy)
      mode_reg <= io_req.wdata[`EAC_BIT_PM_HI:`EAC_BIT_PM_LO];
  end

  // Ready enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rie_reg <= 1'b0;
    else if (wr_ctrl)
      rie_reg <= io_req.wdata[`EAC_BIT_RIE];
  end

  // Master enable with four-cycle window
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mpe_reg <= 1'b0;
      mpe_cnt_reg <= 3'd0;
    end
    else if (wr_ctrl && io_req.wdata[`EAC_BIT_MPE])
    begin
      mpe_reg <= 1'b1;
      mpe_cnt_reg <= 3'(`EAC_MPE_WINDOW);
    end
    else if (mpe_cnt_reg != 3'd0)
    begin
      mpe_cnt_reg <= mpe_cnt_reg - 3'd1;
      if (mpe_cnt_reg == 3'd1)
        mpe_reg <= 1'b0;
    end
  end

  // Address, frozen while programming
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      adr_reg <= 9'h000;
    else if (io_req.wr && !busy)
    begin
      if (io_req.addr == `EAC_OFF_ADRL)
        adr_reg[7:0] <= io_req.wdata;
      else if (io_req.addr == `EAC_OFF_ADRH)
        adr_reg[8] <= io_req.wdata[0];
    end
  end

  // Data: software byte or fetched byte
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      data_reg <= 8'h00;
    else if (rd_start)
      data_reg <= nv_rdata;
    else if (io_req.wr && io_req.addr == `EAC_OFF_DATA && !busy)
      data_reg <= io_req.wdata;
  end

  // Read strobe seen for one cycle only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      re_reg <= 1'b0;
    else
      re_reg <= rd_start;
  end

  // Programming sequencer; timer loaded by mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= EAC_ST_IDLE;
      timer_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        EAC_ST_IDLE:
          if (pe_start)
          begin
            state_reg <= EAC_ST_PROG;
            timer_reg <= (mode_now == EAC_PM_ATOMIC) ?
              TW'(CYC_ATOMIC - 1) : TW'(CYC_SPLIT - 1);
          end
        EAC_ST_PROG:
          if (timer_reg == '0)
            state_reg <= EAC_ST_DONE;
          else
            timer_reg <= timer_reg - TW'(1);
        EAC_ST_DONE:
          state_reg <= EAC_ST_IDLE;
        default:
          state_reg <= EAC_ST_IDLE;
      endcase
    end
  end

  // Core stall counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stall_cnt_reg <= 3'd0;
    else if (pe_start)
      stall_cnt_reg <= 3'(`EAC_PE_STALL);
    else if (rd_start)
      stall_cnt_reg <= 3'(`EAC_RD_STALL);
    else if (stall_cnt_reg != 3'd0)
      stall_cnt_reg <= stall_cnt_reg - 3'd1;
  end

  assign ctrl_view = {2'b00, mode_reg, rie_reg, mpe_reg, busy,
    re_reg};

  // Registered outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_rdata <= 8'h00;
      nv_cmd <= '0;
      nv_busy <= 1'b0;
      cpu_stall <= 1'b0;
      ready_irq <= 1'b0;
    end
    else
    begin
      unique case (io_req.addr)
        `EAC_OFF_CTRL: io_rdata <= ctrl_view;
        `EAC_OFF_DATA: io_rdata <= data_reg;
        `EAC_OFF_ADRL: io_rdata <= adr_reg[7:0];
        `EAC_OFF_ADRH: io_rdata <= {7'h00, adr_reg[8]};
        default: io_rdata <= 8'h00;
      endcase
      if (pe_start)
      begin
        nv_cmd.erase <= (mode_now != EAC_PM_WRITE);
        nv_cmd.write <= (mode_now != EAC_PM_ERASE);
        nv_cmd.addr <= adr_reg;
        nv_cmd.data <= data_reg;
      end
      else if (state_reg == EAC_ST_DONE)
        nv_cmd <= '0;
      nv_busy <= pe_start || (busy && state_reg != EAC_ST_DONE);
      cpu_stall <= pe_start || rd_start || stall_cnt_reg > 3'd1;
      ready_irq <= rie_reg && global_irq_en && !busy
        && !pe_start;
    end
  end

  // Programming begins right after an armed request
  sequence s_armed_req;
    pe_req && mpe_reg && !busy && mode_now != EAC_PM_RSVD;
  endsequence
  property p_pe_start;
    @(posedge clk) disable iff (!rst_n)
    s_armed_req |=> nv_busy && state_reg == EAC_ST_PROG;
  endproperty
  a_pe_start: assert property (p_pe_start)
    else $error("armed program enable did not start");

  property p_no_mpe;
    @(posedge clk) disable iff (!rst_n)
    pe_req && !mpe_reg && !busy |=> !nv_busy;
  endproperty
  a_no_mpe: assert property (p_no_mpe)
    else $error("program started without master enable");

  // A fresh arming write restarts the window, so only an unbroken
  // run of four cycles must end in a cleared bit
  sequence s_mpe_wr;
    wr_ctrl && io_req.wdata[`EAC_BIT_MPE];
  endsequence
  property p_mpe_clear;
    @(posedge clk) disable iff (!rst_n)
    s_mpe_wr ##1 !(wr_ctrl && io_req.wdata[`EAC_BIT_MPE]) [*4]
      |=> !mpe_reg;
  endproperty
  a_mpe_clear: assert property (p_mpe_clear)
    else $error("master enable window wrong");

  property p_mpe_hold;
    @(posedge clk) disable iff (!rst_n)
    s_mpe_wr |=> mpe_reg [*4];
  endproperty
  a_mpe_hold: assert property (p_mpe_hold)
    else $error("master enable dropped inside window");

  property p_mode_hold;
    @(posedge clk) disable iff (!rst_n)
    busy |=> $stable(mode_reg);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed while programming");

  property p_adr_hold;
    @(posedge clk) disable iff (!rst_n)
    busy |=> $stable(adr_reg);
  endproperty
  a_adr_hold: assert property (p_adr_hold)
    else $error("address changed while programming");

  property p_pe_stall;
    @(posedge clk) disable iff (!rst_n)
    pe_start |=> cpu_stall [*2] ##1 !cpu_stall;
  endproperty
  a_pe_stall: assert property (p_pe_stall)
    else $error("program stall not two cycles");

  property p_rd_stall;
    @(posedge clk) disable iff (!rst_n)
    rd_start |=> cpu_stall [*4] ##1 (!cpu_stall || $past(pe_start)
      || $past(rd_start));
  endproperty
  a_rd_stall: assert property (p_rd_stall)
    else $error("read stall not four cycles");

  property p_rd_data;
    @(posedge clk) disable iff (!rst_n)
    rd_start |=> data_reg == $past(nv_rdata) && re_reg ##1 !re_reg
      || $past(rd_start);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("read byte not latched");

  property p_irq;
    @(posedge clk) disable iff (!rst_n)
    ready_irq |-> $past(rie_reg) && $past(global_irq_en)
      && !nv_busy;
  endproperty
  a_irq: assert property (p_irq)
    else $error("ready request without enables");

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
    io_req.addr == `EAC_OFF_CTRL |=> io_rdata[7:6] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits not zero");

endmodule
`default_nettype wire

// [sim/eac_nv_model.sv]
/*
  Behavioural EEPROM array on the far side of the controller.
  Assumes nv_cmd stands steady while the controller programs.
*/
`timescale 1ns/1ns
`default_nettype none
module eac_nv_model
  import eac_pkg::*;
(
  input wire logic clk, // Core clock
  input wire eac_io_t io_req, // Snooped core access
  input wire eac_nv_cmd_t nv_cmd, // Array command
  input wire logic nv_busy, // Programming level
  output logic [7:0] nv_rdata // Byte at shadow address
);
  logic [7:0] mem [512];
  logic [8:0] adr = '0;
  logic busy_q = 1'b0;
  eac_nv_cmd_t held = '0;

  // Address shadow; the controller freezes its copy while busy
  always @(posedge clk)
  begin
    if (io_req.wr && !nv_busy && io_req.addr == 6'h21)
      adr[7:0] <= io_req.wdata;
    if (io_req.wr && !nv_busy && io_req.addr == 6'h22)
      adr[8] <= io_req.wdata[0];
  end

  // Cells change only when the operation ends, as on a real array
  always @(posedge clk)
  begin
    if (nv_cmd.erase || nv_cmd.write)
      held <= nv_cmd;
    busy_q <= nv_busy;
    if (busy_q && !nv_busy)
      mem[held.addr] <= (held.erase ? 8'hFF : mem[held.addr]) &
        (held.write ? held.data : 8'hFF);
  end

  // Known start pattern
  initial
  begin
    for (int i = 0; i < 512; i++)
      mem[i] = 8'(i) ^ 8'h5A;
  end

  assign nv_rdata = mem[adr];
endmodule
`default_nettype wire

// [sim/tb.sv]
/*
  Self-checking bench of the EEPROM access controller.
  Assumes short programming times set through the parameters.
*/
`timescale 1ns/1ns
`default_nettype none
`include "eac_cfg.svh"
`define CHK(a, e) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
      errors++; \
      $display("[ERR] %0t got %h exp %h", $time, a, e); \
    end \
  end
module tb;
  import eac_pkg::*;
  localparam int CYC_A = 40;
  localparam int CYC_S = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  eac_io_t io_req = '0;
  logic gie = 1'b0;
  logic [7:0] io_rdata;
  logic [7:0] nv_rdata;
  eac_nv_cmd_t nv_cmd;
  logic nv_busy;
  logic cpu_stall;
  logic ready_irq;
  int errors = 0;
  int samples_checked = 0;
  int mm [512];
  logic [7:0] rv;
  int n;

  eac_ctrl #(.CLK_HZ(1000000), .T_ATOMIC_US(40), .T_SPLIT_US(20)) uut (
    .clk(clk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata),
    .global_irq_en(gie), .nv_rdata(nv_rdata), .nv_cmd(nv_cmd),
    .nv_busy(nv_busy), .cpu_stall(cpu_stall), .ready_irq(ready_irq));
  eac_nv_model u_nv (.clk(clk), .io_req(io_req), .nv_cmd(nv_cmd),
    .nv_busy(nv_busy), .nv_rdata(nv_rdata));

  // 25 MHz core clock
  always #20 clk = ~clk;

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    io_req <= '0;
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    io_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    io_req <= '0;
    #1;
    rv = io_rdata;
  endtask

  // Counts edges while stall (st=1) or busy stays high
  task automatic hold_len(input bit st);
    n = 0;
    while ((st ? cpu_stall : nv_busy) === 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic prog(input int m, input int a, input int d);
    logic [7:0] c;
    c = 8'(m << 4);
    wr(`EAC_OFF_ADRH, 8'(a >> 8));
    wr(`EAC_OFF_ADRL, 8'(a));
    wr(`EAC_OFF_DATA, 8'(d));
    wr(`EAC_OFF_CTRL, c | 8'h08);
    wr(`EAC_OFF_CTRL, c | 8'h0C);
    wr(`EAC_OFF_CTRL, c | 8'h0E);
    #1;
    `CHK(nv_busy, 1'(m != 3))
    if (m != 3)
    begin
      `CHK(nv_cmd, {1'(m != 2), 1'(m != 1), 9'(a), 8'(d)})
      `CHK(ready_irq, 1'b0)
      hold_len(1);
      `CHK(n, 2)
      // Mode change, read strobe and new address all must bounce
      wr(`EAC_OFF_CTRL, 8'h3B ^ c);
      wr(`EAC_OFF_ADRL, ~8'(a));
      rd(`EAC_OFF_CTRL);
      `CHK(rv[1], 1'b1)
      hold_len(0);
      n = n + 8 - (m != 0 ? CYC_S : CYC_A);
      `CHK(n >= 0 && n <= 2, 1'b1)
      mm[a] = m == 1 ? 255 : (m == 2 ? mm[a] & d : d);
    end
    rd(`EAC_OFF_CTRL);
    `CHK(rv & 8'hF0, c)
    rd(`EAC_OFF_ADRL);
    `CHK(rv, 8'(a))
    `CHK(ready_irq, 1'b1)
    wr(`EAC_OFF_CTRL, c | 8'h09);
    #1;
    hold_len(1);
    `CHK(n, 4)
    rd(`EAC_OFF_DATA);
    `CHK(rv, 8'(mm[a]))
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #(40 * 4000);
    errors++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    void'($urandom(49198));
    for (int i = 0; i < 512; i++)
      mm[i] = (i ^ 'h5A) & 'hFF;
    do_reset();
    rd(`EAC_OFF_CTRL);
    `CHK(rv, 8'h00)
    @(posedge clk);
    gie <= 1'b1;
    wr(`EAC_OFF_ADRH, 8'hFF);
    rd(`EAC_OFF_ADRH);
    `CHK(rv, 8'h01)
    $display("test registers done");
    for (int m = 0; m < 4; m++)
      prog(m, $urandom % 512, $urandom % 256);
    $display("test modes done");
    wr(`EAC_OFF_CTRL, 8'h04);
    rd(`EAC_OFF_CTRL);
    `CHK(rv[2], 1'b1)
    repeat (6) @(posedge clk);
    rd(`EAC_OFF_CTRL);
    `CHK(rv[2], 1'b0)
    wr(`EAC_OFF_CTRL, 8'h02);
    #1;
    `CHK(nv_busy, 1'b0)
    $display("test arming done");
    wr(`EAC_OFF_CTRL, 8'h08);
    @(posedge clk);
    #1;
    `CHK(ready_irq, 1'b1)
    @(posedge clk);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(ready_irq, 1'b0)
    wr(`EAC_OFF_CTRL, 8'h20);
    do_reset();
    rd(`EAC_OFF_CTRL);
    `CHK(rv, 8'h00)
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire
